// ===== bbd_pkg.sv
// Opcodes, lengths, cycle counts and field layouts for the bit/branch unit.
// Function
// - 8B carry AND bit, 3 bytes, 4 cycles.
// - 6B carry OR bit, 3 bytes, 5 cycles.
// - AB carry XOR bit, 3 bytes, 5 cycles.
// - Load carry from bit, 3 bytes, 4 cycles.
// - Bit test sets Z, N, V; 0C/1C.
// - Clear/set memory bit families, 2 bytes, 4 cycles.
// - 2B/0B clear/set accumulator bit, 2 cycles.
// - 20 clears carry, A0 sets carry.
// - 40 clears page flag, C0 sets it.
// - 80 clears overflow in 2 cycles.
// - 4B inverts memory bit, flags untouched.
// - EB stores carry into bit, 6 cycles.
// - 5C compares, writes memory AND NOT accumulator.
// - 3C compares, writes memory OR accumulator.
// - Branch on accumulator or page bit value.
// - 50/D0 branch on carry clear/set.
// - F0/70 branch on zero set/clear.
// - 90/10 branch on negative set/clear.
// - 2F always branches, 4 cycles.
package bbd_pkg;
  // Fixed opcodes.
  localparam logic [7:0] OPC_CARRY_AND = 8'h8b, OPC_CARRY_OR = 8'h6b;
  localparam logic [7:0] OPC_CARRY_XOR = 8'hab, OPC_LOAD_CARRY = 8'hcb;
  localparam logic [7:0] OPC_BIT_DP = 8'h0c, OPC_BIT_ABS = 8'h1c;
  localparam logic [7:0] OPC_CLR_ACC = 8'h2b, OPC_SET_ACC = 8'h0b;
  localparam logic [7:0] OPC_CLR_CARRY = 8'h20, OPC_SET_CARRY = 8'ha0;
  localparam logic [7:0] OPC_CLR_PAGE = 8'h40, OPC_SET_PAGE = 8'hc0;
  localparam logic [7:0] OPC_CLR_OVF = 8'h80, OPC_INVERT = 8'h4b;
  localparam logic [7:0] OPC_STORE_CARRY = 8'heb, OPC_TEST_CLR = 8'h5c;
  localparam logic [7:0] OPC_TEST_SET = 8'h3c, OPC_BR_C0 = 8'h50;
  localparam logic [7:0] OPC_BR_C1 = 8'hd0, OPC_BR_Z1 = 8'hf0;
  localparam logic [7:0] OPC_BR_Z0 = 8'h70, OPC_BR_NEG = 8'h90;
  localparam logic [7:0] OPC_BR_POS = 8'h10, OPC_BR_ALWAYS = 8'h2f;
  // Low nibbles of the bit-numbered families; opcode bit 4 picks clear.
  localparam logic [3:0] FAM_MEM_BIT = 4'h1, FAM_BR_ACC = 4'h2;
  localparam logic [3:0] FAM_BR_DP = 4'h3;
  localparam int OPC_FAM_CLR = 4, OPC_BIT_MSB = 7, OPC_BIT_LSB = 5;
  // Third byte of a memory-bit operand: bit, invert, high address.
  localparam int MB_BIT_MSB = 7, MB_BIT_LSB = 5, MB_INV = 4, MB_AHI_MSB = 3;
  localparam int ACC_BIT_MSB = 2, SIGN_BIT = 7, OVF_BIT = 6;
  localparam logic [15:0] DP_PAGE_OFS = 16'h0100, PC_RESET = 16'h0000;
  // Lengths in bytes.
  localparam logic [1:0] LEN_ONE = 2'h1, LEN_TWO = 2'h2, LEN_THREE = 2'h3;
  // Cycle counts.
  localparam logic [3:0] CYC_CARRY_AND = 4'h4, CYC_CARRY_OR = 4'h5;
  localparam logic [3:0] CYC_CARRY_XOR = 4'h5, CYC_LOAD_CARRY = 4'h4;
  localparam logic [3:0] CYC_BIT_DP = 4'h4, CYC_BIT_ABS = 4'h5;
  localparam logic [3:0] CYC_MEM_BIT = 4'h4, CYC_ACC_BIT = 4'h2;
  localparam logic [3:0] CYC_FLAG = 4'h2, CYC_INVERT = 4'h5;
  localparam logic [3:0] CYC_STORE_CARRY = 4'h6, CYC_TEST = 4'h6;
  localparam logic [3:0] CYC_BRA_SHORT = 4'h4, CYC_BRA_LONG = 4'h6;
  localparam logic [3:0] CYC_BRD_SHORT = 4'h5, CYC_BRD_LONG = 4'h7;
  localparam logic [3:0] CYC_BRF_SHORT = 4'h2, CYC_BRF_LONG = 4'h4;
  localparam logic [3:0] CYC_BR_ALWAYS = 4'h4, CYC_NONE = 4'h2;
  localparam logic [3:0] CNT_STEP = 4'h1;

  typedef enum logic [4:0] {
    CLS_NONE, CLS_AND, CLS_OR, CLS_XOR, CLS_LDC, CLS_BITTEST, CLS_CLRMEM,
    CLS_SETMEM, CLS_CLRACC, CLS_SETACC, CLS_CLEAR_CARRY, CLS_SET_CARRY, CLS_CLEAR_PAGE_FLAG,
    CLS_SET_PAGE_FLAG, CLS_CLEAR_OVERFLOW, CLS_NOT, CLS_STC, CLS_TCLR, CLS_TSET, CLS_BR_ACC,
    CLS_BR_DP, CLS_BR_FLAG
  } bbd_class_t;
  typedef enum logic [1:0] {COND_CARRY, COND_ZERO, COND_NEG, COND_TRUE}
    bbd_cond_t;
  typedef enum logic [1:0] {AM_DP, AM_ABS, AM_MBIT} bbd_amode_t;
endpackage : bbd_pkg

// ===== bbd_decode.sv
// Opcode decoder: class, length, cycle counts, bit select and address mode.
module bbd_decode (
  input wire logic [7:0] opcode,
  input wire logic [7:0] b1,
  input wire logic [7:0] b2,
  output bbd_pkg::bbd_class_t cls,
  output logic [1:0] len,
  output logic [3:0] cyc_base,
  output logic [3:0] cyc_taken,
  output logic [2:0] bit_sel,
  output logic bit_inv,
  output bbd_pkg::bbd_cond_t cond,
  output logic cond_pol,
  output bbd_pkg::bbd_amode_t amode,
  output logic mem_read
);
  import bbd_pkg::*;

  // Unknown opcodes fall back to a one-byte, two-cycle no-op.
  always_comb begin
    cls = CLS_NONE;
    len = LEN_ONE;
    cyc_base = CYC_NONE;
    cyc_taken = CYC_NONE;
    bit_sel = b2[MB_BIT_MSB:MB_BIT_LSB];
    bit_inv = b2[MB_INV];
    cond = COND_TRUE;
    cond_pol = 1'b1;
    amode = AM_MBIT;
    mem_read = 1'b1;
    case (opcode)
      OPC_CARRY_AND: begin cls = CLS_AND; len = LEN_THREE; cyc_base = CYC_CARRY_AND; end
      OPC_CARRY_OR: begin cls = CLS_OR; len = LEN_THREE; cyc_base = CYC_CARRY_OR; end
      OPC_CARRY_XOR: begin cls = CLS_XOR; len = LEN_THREE; cyc_base = CYC_CARRY_XOR; end
      OPC_LOAD_CARRY: begin cls = CLS_LDC; len = LEN_THREE; cyc_base = CYC_LOAD_CARRY; end
      OPC_BIT_DP: begin cls = CLS_BITTEST; len = LEN_TWO; cyc_base = CYC_BIT_DP; amode = AM_DP; end
      OPC_BIT_ABS: begin cls = CLS_BITTEST; len = LEN_THREE; cyc_base = CYC_BIT_ABS; amode = AM_ABS; end
      OPC_CLR_ACC, OPC_SET_ACC: begin
        cls = (opcode == OPC_CLR_ACC) ? CLS_CLRACC : CLS_SETACC;
        len = LEN_TWO;
        cyc_base = CYC_ACC_BIT;
        bit_sel = b1[ACC_BIT_MSB:0];
        mem_read = 1'b0;
      end
      OPC_CLR_CARRY: begin cls = CLS_CLEAR_CARRY; mem_read = 1'b0; cyc_base = CYC_FLAG; end
      OPC_SET_CARRY: begin cls = CLS_SET_CARRY; mem_read = 1'b0; cyc_base = CYC_FLAG; end
      OPC_CLR_PAGE: begin cls = CLS_CLEAR_PAGE_FLAG; mem_read = 1'b0; cyc_base = CYC_FLAG; end
      OPC_SET_PAGE: begin cls = CLS_SET_PAGE_FLAG; mem_read = 1'b0; cyc_base = CYC_FLAG; end
      OPC_CLR_OVF: begin cls = CLS_CLEAR_OVERFLOW; mem_read = 1'b0; cyc_base = CYC_FLAG; end
      OPC_INVERT: begin cls = CLS_NOT; len = LEN_THREE; cyc_base = CYC_INVERT; end
      OPC_STORE_CARRY: begin cls = CLS_STC; len = LEN_THREE; cyc_base = CYC_STORE_CARRY; end
      OPC_TEST_CLR, OPC_TEST_SET: begin
        cls = (opcode == OPC_TEST_CLR) ? CLS_TCLR : CLS_TSET;
        len = LEN_THREE;
        cyc_base = CYC_TEST;
        amode = AM_ABS;
      end
      OPC_BR_C0, OPC_BR_C1, OPC_BR_Z1, OPC_BR_Z0, OPC_BR_NEG, OPC_BR_POS,
      OPC_BR_ALWAYS: begin
        cls = CLS_BR_FLAG;
        len = LEN_TWO;
        mem_read = 1'b0;
        cyc_base = CYC_BRF_SHORT;
        cyc_taken = CYC_BRF_LONG;
        cond_pol = (opcode == OPC_BR_C1) || (opcode == OPC_BR_Z1) ||
                   (opcode == OPC_BR_NEG) || (opcode == OPC_BR_ALWAYS);
        if (opcode == OPC_BR_C0 || opcode == OPC_BR_C1) cond = COND_CARRY;
        else if (opcode == OPC_BR_Z0 || opcode == OPC_BR_Z1) cond = COND_ZERO;
        else if (opcode != OPC_BR_ALWAYS) cond = COND_NEG;
        if (opcode == OPC_BR_ALWAYS) begin
          cyc_base = CYC_BR_ALWAYS;
          cyc_taken = CYC_BR_ALWAYS;
        end
      end
      default: begin
        bit_sel = opcode[OPC_BIT_MSB:OPC_BIT_LSB];
        bit_inv = 1'b0;
        cond_pol = ~opcode[OPC_FAM_CLR];
        amode = AM_DP;
        len = LEN_TWO;
        case (opcode[3:0])
          FAM_MEM_BIT: begin
            cls = opcode[OPC_FAM_CLR] ? CLS_CLRMEM : CLS_SETMEM;
            cyc_base = CYC_MEM_BIT;
          end
          FAM_BR_ACC: begin
            cls = CLS_BR_ACC;
            mem_read = 1'b0;
            cyc_base = CYC_BRA_SHORT;
            cyc_taken = CYC_BRA_LONG;
          end
          FAM_BR_DP: begin
            cls = CLS_BR_DP;
            len = LEN_THREE;
            cyc_base = CYC_BRD_SHORT;
            cyc_taken = CYC_BRD_LONG;
          end
          default: begin
            len = LEN_ONE;
            mem_read = 1'b0;
          end
        endcase
      end
    endcase
  end
endmodule : bbd_decode

// ===== bbd_bitalu.sv
// Combinational bit unit: carry logic, memory rewrite and flag results.
module bbd_bitalu (
  input bbd_pkg::bbd_class_t cls,
  input wire logic carry,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [2:0] bit_sel,
  input wire logic bit_inv,
  output logic carry_out,
  output logic [7:0] mem_out,
  output logic [7:0] acc_out,
  output logic n_out,
  output logic z_out,
  output logic v_out,
  output logic mem_bit
);
  import bbd_pkg::*;

  logic [7:0] mask;
  logic [7:0] diff;
  logic opnd;

  assign mask = 8'h01 << bit_sel;
  assign mem_bit = mem[bit_sel];
  assign opnd = mem_bit ^ bit_inv;
  assign diff = acc - mem;

  // Each class touches only its own result; the caller picks what applies.
  always_comb begin
    carry_out = carry;
    mem_out = mem;
    acc_out = acc;
    n_out = diff[SIGN_BIT];
    z_out = (acc == mem);
    v_out = mem[OVF_BIT];
    case (cls)
      CLS_AND: carry_out = carry & opnd;
      CLS_OR: carry_out = carry | opnd;
      CLS_XOR: carry_out = carry ^ opnd;
      CLS_LDC: carry_out = opnd;
      CLS_BITTEST: begin
        n_out = mem[SIGN_BIT];
        z_out = ((acc & mem) == 8'h00);
      end
      CLS_CLRMEM: mem_out = mem & ~mask;
      CLS_SETMEM: mem_out = mem | mask;
      CLS_CLRACC: acc_out = acc & ~mask;
      CLS_SETACC: acc_out = acc | mask;
      CLS_NOT: mem_out = mem ^ mask;
      CLS_STC: mem_out = carry ? (mem | mask) : (mem & ~mask);
      CLS_TCLR: mem_out = mem & ~acc;
      CLS_TSET: mem_out = mem | acc;
      default: mem_out = mem;
    endcase
  end
endmodule : bbd_bitalu

// ===== bbd_core.sv
// Sequencer that runs the bit and branch instruction groups.
module bbd_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] prog_byte0,
  input wire logic [7:0] prog_byte1,
  input wire logic [7:0] prog_byte2,
  input wire logic [7:0] data_rdata,
  input wire logic acc_load,
  input wire logic [7:0] acc_load_data,
  input wire logic flags_load,
  input wire logic [4:0] flags_load_data,
  output logic [15:0] prog_addr,
  output logic [15:0] data_addr,
  output logic [7:0] data_wdata,
  output logic data_rd,
  output logic data_we,
  output logic [7:0] acc,
  output logic flag_n,
  output logic flag_v,
  output logic flag_g,
  output logic flag_z,
  output logic flag_c,
  output logic instr_done,
  output logic illegal_op
);
  import bbd_pkg::*;

  typedef enum logic [1:0] {ST_FETCH, ST_READ, ST_MODIFY, ST_HOLD}
    bbd_state_t;

  typedef struct packed {
    bbd_state_t st;
    logic [3:0] cnt;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [15:0] pc;
    logic [7:0] acc;
    logic fn;
    logic fv;
    logic fg;
    logic fz;
    logic fc;
    logic [15:0] daddr;
    logic [7:0] wdata;
    logic rd;
    logic we;
    logic done;
    logic illegal;
    logic taken;
  } bbd_regs_t;

  bbd_regs_t r;
  bbd_regs_t next_r;

  bbd_class_t cls;
  bbd_cond_t cond;
  bbd_amode_t amode;
  logic [7:0] dec_op;
  logic [7:0] dec_b1;
  logic [7:0] dec_b2;
  logic [1:0] len;
  logic [3:0] cyc_base;
  logic [3:0] cyc_taken;
  logic [3:0] cyc_last;
  logic [2:0] bit_sel;
  logic bit_inv;
  logic cond_pol;
  logic mem_read;
  logic cond_val;
  logic alu_c;
  logic alu_n;
  logic alu_z;
  logic alu_v;
  logic alu_mbit;
  logic [7:0] alu_mem;
  logic [7:0] alu_acc;
  logic [7:0] rel;
  logic [15:0] ea;
  logic [15:0] pc_next;
  logic start;

  // The decoder looks at the fetch bytes only while a new opcode arrives.
  assign start = (r.st == ST_FETCH) && run;
  assign dec_op = (r.st == ST_FETCH) ? prog_byte0 : r.op;
  assign dec_b1 = (r.st == ST_FETCH) ? prog_byte1 : r.b1;
  assign dec_b2 = (r.st == ST_FETCH) ? prog_byte2 : r.b2;

  bbd_decode u_decode (
    .opcode(dec_op),
    .b1(dec_b1),
    .b2(dec_b2),
    .cls(cls),
    .len(len),
    .cyc_base(cyc_base),
    .cyc_taken(cyc_taken),
    .bit_sel(bit_sel),
    .bit_inv(bit_inv),
    .cond(cond),
    .cond_pol(cond_pol),
    .amode(amode),
    .mem_read(mem_read)
  );

  bbd_bitalu u_bitalu (
    .cls(cls),
    .carry(r.fc),
    .acc(r.acc),
    .mem(data_rdata),
    .bit_sel(bit_sel),
    .bit_inv(bit_inv),
    .carry_out(alu_c),
    .mem_out(alu_mem),
    .acc_out(alu_acc),
    .n_out(alu_n),
    .z_out(alu_z),
    .v_out(alu_v),
    .mem_bit(alu_mbit)
  );

  // Flag selected by a flag branch.
  always_comb begin
    case (cond)
      COND_CARRY: cond_val = r.fc;
      COND_ZERO: cond_val = r.fz;
      COND_NEG: cond_val = r.fn;
      default: cond_val = 1'b1;
    endcase
  end

  // Operand address; the page flag lifts direct-page accesses by a page.
  always_comb begin
    case (amode)
      AM_DP: ea = {8'h00, dec_b1} | (r.fg ? DP_PAGE_OFS : 16'h0000);
      AM_ABS: ea = {dec_b2, dec_b1};
      default: ea = {4'h0, dec_b2[MB_AHI_MSB:0], dec_b1};
    endcase
  end

  // The offset is relative to the byte after the branch.
  assign rel = (cls == CLS_BR_DP) ? r.b2 : r.b1;
  assign pc_next = r.pc + {14'h0000, len} +
                   (r.taken ? {{8{rel[7]}}, rel} : 16'h0000);
  assign cyc_last = (r.taken ? cyc_taken : cyc_base) - CNT_STEP;

  // Next-state logic for the whole sequencer.
  always_comb begin
    next_r = r;
    next_r.rd = 1'b0;
    next_r.we = 1'b0;
    next_r.done = 1'b0;
    next_r.illegal = 1'b0;
    case (r.st)
      ST_FETCH: begin
        // Software loads only land between instructions, never mid-flight.
        if (!run && acc_load) next_r.acc = acc_load_data;
        if (!run && flags_load) begin
          {next_r.fn, next_r.fv, next_r.fg, next_r.fz, next_r.fc} =
            flags_load_data;
        end
        if (run) begin
          next_r.op = prog_byte0;
          next_r.b1 = prog_byte1;
          next_r.b2 = prog_byte2;
          next_r.cnt = CNT_STEP;
          next_r.taken = 1'b0;
          next_r.illegal = (cls == CLS_NONE);
          case (cls)
            CLS_CLEAR_CARRY: next_r.fc = 1'b0;
            CLS_SET_CARRY: next_r.fc = 1'b1;
            CLS_CLEAR_PAGE_FLAG: next_r.fg = 1'b0;
            CLS_SET_PAGE_FLAG: next_r.fg = 1'b1;
            CLS_CLEAR_OVERFLOW: next_r.fv = 1'b0;
            CLS_CLRACC, CLS_SETACC: next_r.acc = alu_acc;
            CLS_BR_ACC: next_r.taken = (r.acc[bit_sel] == cond_pol);
            CLS_BR_FLAG: next_r.taken = (cond_val == cond_pol);
            default: next_r.taken = 1'b0;
          endcase
          if (mem_read) begin
            next_r.daddr = ea;
            next_r.rd = 1'b1;
            next_r.st = ST_READ;
          end else begin
            next_r.st = ST_HOLD;
          end
        end
      end
      ST_READ: begin
        // Memory returns the byte one edge after the read strobe.
        next_r.cnt = r.cnt + CNT_STEP;
        next_r.st = ST_MODIFY;
      end
      ST_MODIFY: begin
        next_r.cnt = r.cnt + CNT_STEP;
        next_r.st = ST_HOLD;
        case (cls)
          CLS_AND, CLS_OR, CLS_XOR, CLS_LDC: next_r.fc = alu_c;
          CLS_BITTEST: begin
            next_r.fn = alu_n;
            next_r.fz = alu_z;
            next_r.fv = alu_v;
          end
          CLS_TCLR, CLS_TSET: begin
            next_r.fn = alu_n;
            next_r.fz = alu_z;
          end
          CLS_BR_DP: next_r.taken = (alu_mbit == cond_pol);
          default: next_r.taken = r.taken;
        endcase
        // Flags stay as they are for invert and store; only memory moves.
        if (cls == CLS_CLRMEM || cls == CLS_SETMEM || cls == CLS_NOT ||
            cls == CLS_STC || cls == CLS_TCLR || cls == CLS_TSET) begin
          next_r.we = 1'b1;
          next_r.wdata = alu_mem;
        end
      end
      ST_HOLD: begin
        // Padding cycles keep each instruction at its documented length.
        if (r.cnt >= cyc_last) begin
          next_r.st = ST_FETCH;
          next_r.cnt = 4'h0;
          next_r.pc = pc_next;
          next_r.done = 1'b1;
        end else begin
          next_r.cnt = r.cnt + CNT_STEP;
        end
      end
      default: next_r.st = ST_FETCH;
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.st <= ST_FETCH;
      r.pc <= PC_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Every output is a plain copy of a flop.
  assign prog_addr = r.pc;
  assign data_addr = r.daddr;
  assign data_wdata = r.wdata;
  assign data_rd = r.rd;
  assign data_we = r.we;
  assign acc = r.acc;
  assign flag_n = r.fn;
  assign flag_v = r.fv;
  assign flag_g = r.fg;
  assign flag_z = r.fz;
  assign flag_c = r.fc;
  assign instr_done = r.done;
  assign illegal_op = r.illegal;

  // A started instruction of n cycles shows done exactly n edges later.
  sequence s_wait4;
    (!instr_done)[*3] ##1 instr_done;
  endsequence

  property p_and_cycles;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_CARRY_AND |=> s_wait4;
  endproperty
  a_and_cycles: assert property (p_and_cycles) else $error("and bit length");

  // The read byte stands only in the modify cycle, so sample it there.
  property p_or_result;
    @(posedge core_clk) disable iff (rst)
      (r.st == ST_MODIFY && cls == CLS_OR) |=> flag_c ==
        ($past(flag_c) | ($past(data_rdata[bit_sel]) ^ $past(bit_inv)));
  endproperty
  a_or_result: assert property (p_or_result) else $error("or result");

  property p_or_cycles;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_CARRY_OR |=> (!instr_done)[*4] ##1 instr_done;
  endproperty
  a_or_cycles: assert property (p_or_cycles) else $error("or bit length");

  property p_ldc_carry;
    @(posedge core_clk) disable iff (rst)
      (r.st == ST_MODIFY && cls == CLS_LDC) |=>
        flag_c == ($past(data_rdata[bit_sel]) ^ $past(bit_inv));
  endproperty
  a_ldc_carry: assert property (p_ldc_carry) else $error("carry load");

  property p_clear_carry;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_CLR_CARRY |=> !flag_c ##1 instr_done;
  endproperty
  a_clear_carry: assert property (p_clear_carry) else $error("carry not cleared");

  property p_set_page_flag;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_SET_PAGE |=> flag_g ##1 instr_done;
  endproperty
  a_set_page_flag: assert property (p_set_page_flag) else $error("page flag not set");

  property p_clear_overflow;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_CLR_OVF |=> !flag_v ##1 instr_done;
  endproperty
  a_clear_overflow: assert property (p_clear_overflow) else $error("overflow not cleared");

  property p_setacc;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_SET_ACC |=>
        acc[$past(prog_byte1[2:0])] ##1 instr_done;
  endproperty
  a_setacc: assert property (p_setacc) else $error("acc bit not set");

  property p_stc_cycles;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_STORE_CARRY |=>
        (!instr_done)[*5] ##1 instr_done;
  endproperty
  a_stc_cycles: assert property (p_stc_cycles) else $error("store length");

  property p_tclr_write;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_TEST_CLR |=> ##2
        (data_we && data_wdata == ($past(data_rdata) & ~acc));
  endproperty
  a_tclr_write: assert property (p_tclr_write) else $error("test clear write");

  property p_bcc_short;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_BR_C0 && flag_c |=> !instr_done ##1
        instr_done;
  endproperty
  a_bcc_short: assert property (p_bcc_short) else $error("untaken length");

  property p_bra_target;
    @(posedge core_clk) disable iff (rst)
      start && prog_byte0 == OPC_BR_ALWAYS |=> ##3 (instr_done &&
        prog_addr == $past(prog_addr, 4) + 16'h0002 +
        {{8{$past(prog_byte1[7], 4)}}, $past(prog_byte1, 4)});
  endproperty
  a_bra_target: assert property (p_bra_target) else $error("branch target");
endmodule : bbd_core

// ===== test_bit_and_branch_instruction_decode.sv
// Self-checking bench for the bit and branch sequencer.
module test_bit_and_branch_instruction_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import bbd_pkg::*;
  logic core_clk, rst, run, acc_load, flags_load, data_rd, data_we;
  logic [7:0] pb0, pb1, pb2, data_rdata, acc_load_data, data_wdata, acc;
  logic [7:0] mem_val, wr_data;
  logic [4:0] flags_load_data;
  logic [15:0] prog_addr, data_addr, exp_pc;
  logic flag_n, flag_v, flag_g, flag_z, flag_c, instr_done, illegal_op;
  int n_fail, compares;
  int n_ill = 0;

  bbd_core dut (.core_clk(core_clk), .rst(rst), .run(run),
    .prog_byte0(pb0), .prog_byte1(pb1), .prog_byte2(pb2),
    .data_rdata(data_rdata), .acc_load(acc_load),
    .acc_load_data(acc_load_data), .flags_load(flags_load),
    .flags_load_data(flags_load_data), .prog_addr(prog_addr),
    .data_addr(data_addr), .data_wdata(data_wdata), .data_rd(data_rd),
    .data_we(data_we), .acc(acc), .flag_n(flag_n), .flag_v(flag_v),
    .flag_g(flag_g), .flag_z(flag_z), .flag_c(flag_c),
    .instr_done(instr_done), .illegal_op(illegal_op));

  // Free-running 200 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Read data is good only in the cycle after a strobe; otherwise the
  // inverse shows, so a sample taken late cannot pass by chance.
  always @(posedge core_clk) data_rdata <= data_rd ? mem_val : ~mem_val;
  always @(posedge core_clk) if (data_we) wr_data <= data_wdata;
  // The illegal pulse is gone by the time done shows, so count it here.
  always @(posedge core_clk) if (illegal_op === 1'b1) n_ill++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // Loads are only taken while idle with run low.
  task automatic setup(input logic [7:0] a, input logic [4:0] f);
    acc_load = 1'b1;
    flags_load = 1'b1;
    acc_load_data = a;
    flags_load_data = f;
    @(posedge core_clk);
    #1;
    acc_load = 1'b0;
    flags_load = 1'b0;
  endtask : setup

  // Starts one instruction, counts cycles to done and checks next pc.
  task automatic exec(input logic [7:0] op, b1, b2, input logic [1:0] len,
                      input logic [15:0] jump, input int cyc);
    int n;
    pb0 = op;
    pb1 = b1;
    pb2 = b2;
    run = 1'b1;
    @(posedge core_clk);
    #1;
    run = 1'b0;
    // The start edge itself is the first cycle of the instruction.
    n = 1;
    while (instr_done !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 20) begin
      n_fail++;
      finish_test();
    end
    exp_pc = exp_pc + 16'(len) + jump;
    chk(16'(n), 16'(cyc));
    chk(prog_addr, exp_pc);
  endtask : exec

  // Carry boolean group over both senses, all bits and operand values.
  task automatic t_carry;
    logic [7:0] ops [4] = '{OPC_CARRY_AND, OPC_CARRY_OR, OPC_CARRY_XOR,
                            OPC_LOAD_CARRY};
    int cyc [4] = '{4, 5, 5, 4};
    logic mb, e;
    for (int j = 0; j < 32; j++) begin
      mb = j[0] ^ j[2];
      mem_val = j[0] ? 8'h01 << j[4:2] : ~(8'h01 << j[4:2]);
      case (j[4:3])
        0: e = j[1] & mb;
        1: e = j[1] | mb;
        2: e = j[1] ^ mb;
        default: e = mb;
      endcase
      setup(8'h00, {4'h0, j[1]});
      exec(ops[j[4:3]], 8'h5a, {j[4:2], j[2], 4'h3}, LEN_THREE, 16'h0,
           cyc[j[4:3]]);
      chk({15'h0, flag_c}, {15'h0, e});
      chk(data_addr, 16'h035a);
    end
    $display("t_carry finished");
  endtask : t_carry

  // Bit test in the upper direct page and in absolute form.
  task automatic t_bit_test;
    setup(8'h3f, 5'b00100);
    mem_val = 8'hc0;
    exec(OPC_BIT_DP, 8'h20, 8'h00, LEN_TWO, 16'h0, 4);
    chk(data_addr, 16'h0120);
    chk({13'h0, flag_n, flag_v, flag_z}, 16'h0007);
    setup(8'h01, 5'b00000);
    mem_val = 8'h41;
    exec(OPC_BIT_ABS, 8'h34, 8'h12, LEN_THREE, 16'h0, 5);
    chk(data_addr, 16'h1234);
    chk({13'h0, flag_n, flag_v, flag_z}, 16'h0002);
    $display("t_bit_test finished");
  endtask : t_bit_test

  // Memory bit rewrites: every set and clear bit, invert and store carry.
  task automatic t_mem_bit;
    setup(8'h00, 5'h00);
    mem_val = 8'h5a;
    for (int k = 0; k < 8; k++) begin
      exec({k[2:0], 5'h01}, 8'h40, 8'h00, LEN_TWO, 16'h0, 4);
      chk({8'h0, wr_data}, {8'h0, mem_val | (8'h01 << k)});
      exec({k[2:0], 5'h11}, 8'h40, 8'h00, LEN_TWO, 16'h0, 4);
      chk({8'h0, wr_data}, {8'h0, mem_val & ~(8'h01 << k)});
    end
    chk(data_addr, 16'h0040);
    setup(8'h00, 5'h1f);
    exec(OPC_INVERT, 8'h00, 8'h43, LEN_THREE, 16'h0, 5);
    chk({8'h0, wr_data}, 16'h005e);
    chk({flag_n, flag_v, flag_g, flag_z, flag_c}, 16'h001f);
    setup(8'h00, 5'h00);
    mem_val = 8'hff;
    exec(OPC_STORE_CARRY, 8'h00, 8'hc3, LEN_THREE, 16'h0, 6);
    chk({8'h0, wr_data}, 16'h00bf);
    $display("t_mem_bit finished");
  endtask : t_mem_bit

  // Accumulator bit clear and set, back to back, every bit.
  task automatic t_acc_bit;
    for (int k = 0; k < 8; k++) begin
      setup(8'h96, 5'h00);
      exec(OPC_CLR_ACC, {5'h0, k[2:0]}, 8'h00, LEN_TWO, 16'h0, 2);
      chk({8'h0, acc}, {8'h0, 8'h96 & ~(8'h01 << k)});
      exec(OPC_SET_ACC, {5'h0, k[2:0]}, 8'h00, LEN_TWO, 16'h0, 2);
      chk({8'h0, acc}, {8'h0, 8'h96 | (8'h01 << k)});
    end
    $display("t_acc_bit finished");
  endtask : t_acc_bit

  // Single-byte flag instructions; other flags must stay put.
  task automatic t_flags;
    logic [7:0] ops [5] = '{OPC_SET_CARRY, OPC_CLR_CARRY, OPC_SET_PAGE,
                            OPC_CLR_PAGE, OPC_CLR_OVF};
    logic [4:0] ef [5] = '{5'h1b, 5'h1a, 5'h1e, 5'h1a, 5'h12};
    setup(8'h00, 5'h1a);
    for (int i = 0; i < 5; i++) begin
      exec(ops[i], 8'h00, 8'h00, LEN_ONE, 16'h0, 2);
      chk({flag_n, flag_v, flag_g, flag_z, flag_c}, 16'(ef[i]));
    end
    // An unknown opcode runs as a one-byte, two-cycle no-op.
    exec(8'h00, 8'h00, 8'h00, LEN_ONE, 16'h0, 2);
    chk(16'(n_ill), 16'h0001);
    $display("t_flags finished");
  endtask : t_flags

  // Test-and-clear and test-and-set on absolute memory.
  task automatic t_test_bits;
    setup(8'h0f, 5'h00);
    mem_val = 8'h3c;
    exec(OPC_TEST_CLR, 8'h78, 8'h05, LEN_THREE, 16'h0, 6);
    chk({8'h0, wr_data}, 16'h0030);
    chk({flag_n, flag_z}, 16'h0002);
    chk(data_addr, 16'h0578);
    setup(8'h3c, 5'h00);
    exec(OPC_TEST_SET, 8'h78, 8'h05, LEN_THREE, 16'h0, 6);
    chk({8'h0, wr_data}, 16'h003c);
    chk({flag_n, flag_z}, 16'h0001);
    $display("t_test_bits finished");
  endtask : t_test_bits

  // Flag branches both ways with forward and backward offsets.
  task automatic t_branch_flag;
    logic [7:0] ops [6] = '{OPC_BR_C0, OPC_BR_C1, OPC_BR_Z1, OPC_BR_Z0,
                            OPC_BR_NEG, OPC_BR_POS};
    logic [4:0] msk [6] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h10, 5'h10};
    logic pol [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] rel;
    logic tk;
    for (int j = 0; j < 12; j++) begin
      rel = j[0] ? 8'hf8 : 8'h10;
      tk = j[0] == pol[j / 2];
      setup(8'h00, j[0] ? msk[j / 2] : 5'h00);
      exec(ops[j / 2], rel, 8'h00, LEN_TWO, tk ? {{8{rel[7]}}, rel} : 16'h0,
           tk ? 4 : 2);
    end
    exec(OPC_BR_ALWAYS, 8'hf0, 8'h00, LEN_TWO, 16'hfff0, 4);
    $display("t_branch_flag finished");
  endtask : t_branch_flag

  // Bit branches on accumulator and direct-page bits, every bit both ways.
  task automatic t_branch_bit;
    logic tk;
    setup(8'h5a, 5'h00);
    mem_val = 8'h5a;
    for (int j = 0; j < 16; j++) begin
      tk = mem_val[j / 2] != j[0];
      exec({j[3:1], j[0], 4'h2}, 8'h08, 8'h00, LEN_TWO, tk ? 16'h8 : 16'h0,
           tk ? 6 : 4);
      exec({j[3:1], j[0], 4'h3}, 8'h60, 8'hfa, LEN_THREE,
           tk ? 16'hfffa : 16'h0, tk ? 7 : 5);
    end
    $display("t_branch_bit finished");
  endtask : t_branch_bit

  // Reset for twelve cycles, then run every scenario in turn.
  initial begin
    {rst, run, acc_load, flags_load} = 4'hf;
    {pb0, pb1, pb2, acc_load_data, mem_val} = 40'h0;
    run = 1'b0;
    acc_load = 1'b0;
    flags_load = 1'b0;
    flags_load_data = 5'h00;
    exp_pc = 16'h0000;
    n_fail = 0;
    compares = 0;
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    t_carry();
    t_bit_test();
    t_mem_bit();
    t_acc_bit();
    t_flags();
    t_test_bits();
    t_branch_flag();
    t_branch_bit();
    finish_test();
  end
endmodule : test_bit_and_branch_instruction_decode
